// >>> ivm_vector_map.sv
`timescale 1ns/1ps
// Function
// R1: fixed priority follows vector order, higher offset wins
// R2: vector base register lets software relocate the table
// R3: vector is 16-bit: base high byte plus fixed low-byte offset
// R4: unimplemented trap F8, software trap F6, unmaskable, no local enable
// R5: link error F4, masked by X only, wakes from stop and wait
// R6: link external F2, I masked, link irq enable, wakes stop and wait
// R7: periodic timer F0, I masked, periodic timeout enable
// R8: serial D8, I masked, rx or tx-empty enable, wakes wait only
// R9: oscillator C8, I masked, own enable, no wake
// R10: lock C6, I masked, lock enable, no wake
// R11: flash error BA, I masked, single or double fault enable, no wake
// R12: flash command B8, I masked, command-complete enable, wakes wait only
// R13: low voltage 8A, I masked, low voltage enable, no stop wake
// R14: spurious vector 80 when request vanishes before service
// R15: reserved slots never requested
// R16: highest-priority pending enabled request is presented
module ivm_vector_map (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_base_we,
	input  wire logic [7:0]  i_base_wdata,
	input  wire logic        i_unimp_trap,
	input  wire logic        i_software_trap_instr,
	input  wire logic        i_die_link_err,
	input  wire logic        i_die_link_ext,
	input  wire logic        i_periodic_timer,
	input  wire logic        i_serial_rx,
	input  wire logic        i_serial_tx_empty,
	input  wire logic        i_osc_status,
	input  wire logic        i_pll_lock,
	input  wire logic        i_flash_single_fault,
	input  wire logic        i_flash_double_fault,
	input  wire logic        i_flash_cmd_done,
	input  wire logic        i_low_voltage_warning,
	input  wire logic        i_die_link_irq_enable,
	input  wire logic        i_periodic_timeout_irq_enable,
	input  wire logic        i_serial_rx_irq_enable,
	input  wire logic        i_serial_tx_empty_irq_enable,
	input  wire logic        i_oscillator_irq_enable,
	input  wire logic        i_lock_irq_enable,
	input  wire logic        i_single_fault_irq_enable,
	input  wire logic        i_double_fault_irq_enable,
	input  wire logic        i_command_complete_irq_enable,
	input  wire logic        i_low_voltage_irq_enable,
	input  wire logic        i_cond_i,
	input  wire logic        i_cond_x,
	input  wire logic        i_in_stop,
	input  wire logic        i_in_wait,
	input  wire logic        i_fetch,
	output logic             o_irq,
	output logic      [15:0] o_vector,
	output logic      [7:0]  o_vector_base,
	output logic             o_wake
);
	logic [7:0]  vector_base_reg;
	logic [10:0] raw;
	logic [10:0] en;
	logic [10:0] active;
	logic [3:0]  win;
	logic        any;
	logic [7:0]  ofs_next;
	logic [15:0] vector_reg;
	logic        wake_reg;

	// raw requests; the serial and flash-error lines are merged here so each gets one slot
	assign raw = {i_unimp_trap, i_software_trap_instr, i_die_link_err, i_die_link_ext,
		i_periodic_timer, i_serial_rx | i_serial_tx_empty, i_osc_status, i_pll_lock,
		i_flash_single_fault | i_flash_double_fault, i_flash_cmd_done,
		i_low_voltage_warning}; // [R15]
	// per-source gating of each half keeps a disabled half from sneaking in via the other
	assign en = {1'b1, 1'b1, 1'b1, // [R4] [R5]
		i_die_link_irq_enable, // [R6]
		i_periodic_timeout_irq_enable, // [R7]
		(i_serial_rx & i_serial_rx_irq_enable)
			| (i_serial_tx_empty & i_serial_tx_empty_irq_enable), // [R8]
		i_oscillator_irq_enable, // [R9]
		i_lock_irq_enable, // [R10]
		(i_flash_single_fault & i_single_fault_irq_enable)
			| (i_flash_double_fault & i_double_fault_irq_enable), // [R11]
		i_command_complete_irq_enable, // [R12]
		i_low_voltage_irq_enable}; // [R13]

	ivm_gate u_gate (
		.i_raw      (raw),
		.i_local_en (en),
		.i_cond_i   (i_cond_i),
		.i_cond_x   (i_cond_x),
		.o_active   (active)
	);

	always_comb begin
		win = 4'h0;
		any = 1'b0;
		for (int k = 0; k < 11; k++) begin
			if (active[k]) begin
				win = 4'(k); // [R1] [R16]
				any = 1'b1;
			end
		end
		ofs_next = any ? ivm_pkg::OFS_TABLE[win*8 +: 8] : ivm_pkg::OFS_SPUR; // [R14]
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			vector_base_reg <= ivm_pkg::BASE_RST;
		end else if (i_base_we) begin
			vector_base_reg <= i_base_wdata; // [R2]
		end
	end

	// vector is latched at fetch so a vanished request still yields the spurious slot
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			vector_reg <= {ivm_pkg::BASE_RST, ivm_pkg::OFS_SPUR};
		end else if (i_fetch) begin
			vector_reg <= {vector_base_reg, ofs_next}; // [R3] [R14]
		end
	end

	// masked or disabled sources never wake the core, same gating as the vector path
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			wake_reg <= 1'b0;
		end else begin
			wake_reg <= (i_in_stop & |(active & ivm_pkg::WAKE_STOP)) // [R7] [R9] [R10] [R11]
				| (i_in_wait & |(active & ivm_pkg::WAKE_WAIT)); // [R5] [R6] [R8] [R12] [R13]
		end
	end

	assign o_irq         = any;
	assign o_vector      = vector_reg;
	assign o_vector_base = vector_base_reg;
	assign o_wake        = wake_reg;

	a_fetch_vector: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_fetch |=> o_vector == {$past(vector_base_reg), $past(ofs_next)}) // [R3]
		else $error("vector not latched at fetch");
	a_spurious_vec: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && !any) |=> o_vector[7:0] == 8'h80) // [R14]
		else $error("spurious vector missing");
	a_trap_top: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && i_unimp_trap) |=> o_vector[7:0] == 8'hf8) // [R4]
		else $error("trap not highest");
	a_sw_trap_unmask: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && i_software_trap_instr && !i_unimp_trap) |=> o_vector[7:0] == 8'hf6) // [R4]
		else $error("software trap lost");
	a_err_xmask: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_die_link_err && !i_cond_x) |-> o_irq) // [R5]
		else $error("link error not raised");
	a_imask_block: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_cond_i && i_cond_x && !i_unimp_trap && !i_software_trap_instr) |-> !o_irq) // [R6]
		else $error("i mask ignored");
	a_base_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_base_we |=> o_vector_base == $past(i_base_wdata)) // [R2]
		else $error("base not written");
	a_no_stop_wake: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_in_stop && !i_in_wait && (active & 11'h1c0) == 11'h000) |=> !o_wake) // [R8] [R13]
		else $error("wrong stop wake");
	a_prio_order: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && active[1] && active[0]) |=> o_vector[7:0] != 8'h8a) // [R16]
		else $error("priority wrong");
	a_sw_trap_nomask: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_software_trap_instr && i_cond_i && i_cond_x) |-> o_irq) // [R4]
		else $error("software trap masked");
	a_err_wakes: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_in_stop && i_die_link_err && !i_cond_x) |=> o_wake) // [R5]
		else $error("link error did not wake");
	a_lnk_err_x: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && i_die_link_err && i_cond_x) |=> o_vector[7:0] != 8'hf4) // [R5]
		else $error("x mask ignored");
	a_ext_wakes: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		((i_in_stop || i_in_wait) && i_die_link_ext && i_die_link_irq_enable && !i_cond_i)
		|=> o_wake) // [R6]
		else $error("link external did not wake");
	a_ext_enable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && !i_die_link_irq_enable) |=> o_vector[7:0] != 8'hf2) // [R6]
		else $error("link external taken while disabled");
	a_timer_vector: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && i_periodic_timer && i_periodic_timeout_irq_enable && !i_cond_i
			&& !i_unimp_trap && !i_software_trap_instr && !i_die_link_err && !i_die_link_ext)
		|=> o_vector[7:0] == 8'hf0) // [R7]
		else $error("periodic timer vector wrong");
	a_timer_enable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && !i_periodic_timeout_irq_enable) |=> o_vector[7:0] != 8'hf0) // [R7]
		else $error("periodic timer taken while disabled");
	a_serial_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && !(i_serial_rx && i_serial_rx_irq_enable)
			&& !(i_serial_tx_empty && i_serial_tx_empty_irq_enable))
		|=> o_vector[7:0] != 8'hd8) // [R8]
		else $error("serial taken while disabled");
	a_serial_wait: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_in_wait && i_serial_rx && i_serial_rx_irq_enable && !i_cond_i) |=> o_wake) // [R8]
		else $error("serial did not wake from wait");
	a_osc_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && !i_oscillator_irq_enable) |=> o_vector[7:0] != 8'hc8) // [R9]
		else $error("oscillator taken while disabled");
	a_lock_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && !i_lock_irq_enable) |=> o_vector[7:0] != 8'hc6) // [R10]
		else $error("lock taken while disabled");
	a_ferr_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && !(i_flash_single_fault && i_single_fault_irq_enable)
			&& !(i_flash_double_fault && i_double_fault_irq_enable))
		|=> o_vector[7:0] != 8'hba) // [R11]
		else $error("flash error taken while disabled");
	a_cmd_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && !i_command_complete_irq_enable) |=> o_vector[7:0] != 8'hb8) // [R12]
		else $error("flash command taken while disabled");
	a_cmd_wait: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_in_wait && i_flash_cmd_done && i_command_complete_irq_enable && !i_cond_i)
		|=> o_wake) // [R12]
		else $error("flash command did not wake from wait");
	a_quiet_no_wake: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		((active & 11'h1e2) == 11'h000) |=> !o_wake) // [R9] [R10] [R11] [R13]
		else $error("wake from a source that cannot wake");
	a_lvw_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && !i_low_voltage_irq_enable) |=> o_vector[7:0] != 8'h8a) // [R13]
		else $error("low voltage taken while disabled");
	a_reserved_slot: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_fetch |=> o_vector[7:0] inside {8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hf0, 8'hd8,
			8'hc8, 8'hc6, 8'hba, 8'hb8, 8'h8a, 8'h80}) // [R15]
		else $error("reserved vector presented");
	a_irq_needs_req: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(raw == 11'h000) |-> !o_irq) // [R15]
		else $error("request without a source");
	a_pend_served: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_fetch && o_irq) |=> o_vector[7:0] != 8'h80) // [R16]
		else $error("pending request given spurious vector");
	c_spur: cover property (@(posedge i_core_clk) i_fetch && !any);
	c_two: cover property (@(posedge i_core_clk) i_fetch && active[5] && active[2]);
	c_wake: cover property (@(posedge i_core_clk) o_wake);
	c_trap_fetch: cover property (@(posedge i_core_clk) i_fetch && i_unimp_trap);
	c_base_move: cover property (@(posedge i_core_clk) i_base_we && i_base_wdata != 8'hff);
endmodule // ivm_vector_map

// >>> ivm_pkg.sv
package ivm_pkg;
	localparam int NSRC = 11;
	localparam logic [7:0] OFS_UNIMP   = 8'hf8;
	localparam logic [7:0] OFS_SW_TRAP = 8'hf6;
	localparam logic [7:0] OFS_LNK_ERR = 8'hf4;
	localparam logic [7:0] OFS_LNK_EXT = 8'hf2;
	localparam logic [7:0] OFS_PER     = 8'hf0;
	localparam logic [7:0] OFS_SER     = 8'hd8;
	localparam logic [7:0] OFS_OSC     = 8'hc8;
	localparam logic [7:0] OFS_LOCK    = 8'hc6;
	localparam logic [7:0] OFS_FERR    = 8'hba;
	localparam logic [7:0] OFS_FCMD    = 8'hb8;
	localparam logic [7:0] OFS_LVW     = 8'h8a;
	localparam logic [7:0] OFS_SPUR    = 8'h80;
	localparam logic [7:0] BASE_RST    = 8'hff;
	// source index order: 0 lowest priority .. 10 highest
	localparam logic [NSRC*8-1:0] OFS_TABLE = {OFS_UNIMP, OFS_SW_TRAP, OFS_LNK_ERR, OFS_LNK_EXT,
		OFS_PER, OFS_SER, OFS_OSC, OFS_LOCK, OFS_FERR, OFS_FCMD, OFS_LVW};
	// wake capability per source, same order
	// periodic timer wakes from both modes as a chosen default
	localparam logic [NSRC-1:0] WAKE_STOP = 11'h1c0;
	localparam logic [NSRC-1:0] WAKE_WAIT = 11'h1e2;
	localparam logic [NSRC-1:0] X_MASKED  = 11'h100;
	localparam logic [NSRC-1:0] I_MASKED  = 11'h0ff;
endpackage

// >>> ivm_gate.sv
`timescale 1ns/1ps
module ivm_gate (
	input  wire logic [10:0] i_raw,
	input  wire logic [10:0] i_local_en,
	input  wire logic        i_cond_i,
	input  wire logic        i_cond_x,
	output logic      [10:0] o_active
);
	genvar g;
	generate
		for (g = 0; g < 11; g++) begin : g_src
			assign o_active[g] = i_raw[g] & i_local_en[g]
				& ~(ivm_pkg::I_MASKED[g] & i_cond_i)
				& ~(ivm_pkg::X_MASKED[g] & i_cond_x);
		end
	endgenerate
endmodule // ivm_gate

// >>> ivm_core_model.sv
`timescale 1ns/1ps
module ivm_core_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_go,
	input  wire logic [15:0] i_vector,
	output logic             o_fetch,
	output logic             o_done,
	output logic      [15:0] o_taken
);
	logic pend;
	initial begin
		o_fetch = 1'b0;
		o_done  = 1'b0;
		pend    = 1'b0;
		o_taken = 16'h0000;
	end
	// vector is read one edge after the fetch edge, never in the same step
	always @(posedge i_core_clk) begin
		o_done <= pend;
		if (pend) o_taken <= i_vector;
		pend <= o_fetch;
		o_fetch <= #1 i_go;
	end
endmodule // ivm_core_model

// >>> test_ivm_vector_map.sv
`timescale 1ns/1ps
module test_ivm_vector_map;
	logic        clk = 1'b0, rst_n = 1'b0, we = 1'b0, go = 1'b0, fetch, irq, wake, done;
	logic [7:0]  wd = 8'h00, base;
	logic [12:0] req = 13'h0000;
	logic [9:0]  en = 10'h000;
	logic [1:0]  cond = 2'h0, lp = 2'h0;
	logic [15:0] vec, taken;
	int          num_errors = 0, checked = 0;
	// rows: request, enable, {i,x}, {stop,wait} -> irq, offset, wake
	logic [36:0] rows [22] = '{
		{13'h1000,10'h000,2'h3,2'h0,1'h1,8'hf8,1'h0}, {13'h0800,10'h000,2'h3,2'h0,1'h1,8'hf6,1'h0},
		{13'h0400,10'h000,2'h2,2'h2,1'h1,8'hf4,1'h1}, {13'h0400,10'h000,2'h1,2'h1,1'h0,8'h80,1'h0},
		{13'h0200,10'h200,2'h0,2'h1,1'h1,8'hf2,1'h1}, {13'h0200,10'h000,2'h0,2'h0,1'h0,8'h80,1'h0},
		{13'h0100,10'h100,2'h0,2'h0,1'h1,8'hf0,1'h0}, {13'h0100,10'h100,2'h2,2'h0,1'h0,8'h80,1'h0},
		{13'h0080,10'h080,2'h0,2'h2,1'h1,8'hd8,1'h0}, {13'h0040,10'h040,2'h0,2'h1,1'h1,8'hd8,1'h1},
		{13'h0080,10'h040,2'h0,2'h0,1'h0,8'h80,1'h0}, {13'h0020,10'h020,2'h0,2'h3,1'h1,8'hc8,1'h0},
		{13'h0010,10'h010,2'h0,2'h3,1'h1,8'hc6,1'h0}, {13'h0008,10'h008,2'h0,2'h3,1'h1,8'hba,1'h0},
		{13'h0004,10'h004,2'h0,2'h0,1'h1,8'hba,1'h0}, {13'h0002,10'h002,2'h0,2'h2,1'h1,8'hb8,1'h0},
		{13'h0002,10'h002,2'h0,2'h1,1'h1,8'hb8,1'h1}, {13'h0001,10'h001,2'h0,2'h2,1'h1,8'h8a,1'h0},
		{13'h1fff,10'h3ff,2'h0,2'h0,1'h1,8'hf8,1'h0}, {13'h07ff,10'h3ff,2'h1,2'h0,1'h1,8'hf2,1'h0},
		{13'h0003,10'h003,2'h0,2'h0,1'h1,8'hb8,1'h0}, {13'h0000,10'h000,2'h0,2'h0,1'h0,8'h80,1'h0}};
	initial forever #25 clk = ~clk;
	ivm_vector_map ivm_vector_map_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_base_we(we),
		.i_base_wdata(wd), .i_unimp_trap(req[12]), .i_software_trap_instr(req[11]),
		.i_die_link_err(req[10]), .i_die_link_ext(req[9]), .i_periodic_timer(req[8]),
		.i_serial_rx(req[7]), .i_serial_tx_empty(req[6]), .i_osc_status(req[5]),
		.i_pll_lock(req[4]), .i_flash_single_fault(req[3]), .i_flash_double_fault(req[2]),
		.i_flash_cmd_done(req[1]), .i_low_voltage_warning(req[0]),
		.i_die_link_irq_enable(en[9]), .i_periodic_timeout_irq_enable(en[8]),
		.i_serial_rx_irq_enable(en[7]), .i_serial_tx_empty_irq_enable(en[6]),
		.i_oscillator_irq_enable(en[5]), .i_lock_irq_enable(en[4]),
		.i_single_fault_irq_enable(en[3]), .i_double_fault_irq_enable(en[2]),
		.i_command_complete_irq_enable(en[1]), .i_low_voltage_irq_enable(en[0]),
		.i_cond_i(cond[1]), .i_cond_x(cond[0]), .i_in_stop(lp[1]), .i_in_wait(lp[0]),
		.i_fetch(fetch), .o_irq(irq), .o_vector(vec), .o_vector_base(base), .o_wake(wake));
	ivm_core_model ivm_core_model_i (.i_core_clk(clk), .i_go(go), .i_vector(vec),
		.o_fetch(fetch), .o_done(done), .o_taken(taken));
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic step;
		@(posedge clk);
		#1;
	endtask
	// drop removes all requests in the step the fetch strobe rises, before the edge that latches the vector
	task automatic fetch_chk(logic [15:0] exp, logic drop);
		go = 1'b1;
		step;
		go = 1'b0;
		if (drop) req = 13'h0000;
		for (int k = 0; k < 8 && done !== 1'b1; k++) step;
		if (done !== 1'b1) begin
			num_errors++;
			end_sim;
		end else begin
			chk("vector", taken, exp);
		end
	endtask
	initial begin
		repeat (8) step;
		rst_n = 1'b1;
		chk("base", 16'(base), 16'h00ff);
		chk("vector", vec, 16'hff80);
		chk("wake", 16'(wake), 16'h0000);
		we = 1'b1;
		wd = 8'h5a;
		step;
		we = 1'b0;
		chk("base", 16'(base), 16'h005a);
		foreach (rows[n]) begin
			{req, en, cond, lp} = rows[n][36:10];
			step;
			chk("irq", 16'(irq), 16'(rows[n][9]));
			chk("wake", 16'(wake), 16'(rows[n][0]));
			fetch_chk({8'h5a, rows[n][8:1]}, 1'b0);
		end
		req = 13'h0400;
		step;
		chk("irq", 16'(irq), 16'h0001);
		fetch_chk(16'h5a80, 1'b1);
		// mid-run reset with a waking source held: wake must drop and come back
		req = 13'h0400;
		lp = 2'h3;
		step;
		chk("wake", 16'(wake), 16'h0001);
		rst_n = 1'b0;
		step;
		rst_n = 1'b1;
		chk("base", 16'(base), 16'h00ff);
		chk("vector", vec, 16'hff80);
		chk("wake", 16'(wake), 16'h0000);
		step;
		chk("wake", 16'(wake), 16'h0001);
		fetch_chk(16'hfff4, 1'b0);
		end_sim;
	end
endmodule // test_ivm_vector_map
